// >>> design/e3mon_top.sv
// e3 receive alarm and bip-4 monitor with wishbone register access
// ==========================================================
// Notes on behaviour
// - two frames with eight+ zeros clear alarm
// - alarm clear sets alarm interrupt status bit 0
// - alarm clear drives alarm pin low
// - alarm clear writes status bit zero
// - consecutive a-bit-one frames declare far-end failure
// - select bit picks three or five frames
// - failure declare sets status two bit 3
// - failure declare sets failure status bit one
// - same count of a-zero frames clears failure
// - failure clear raises interrupt, clears status bit
// - enabled: compare frame bip with next em
// - match sends outgoing a bit zero
// - mismatch sends outgoing a bit one
// - mismatch sets status two bit 2
// - no bip comparison until software enables it
// - two frames with seven-or-fewer zeros declare alarm
// - enabled bip error raises interrupt request
`timescale 1ns/1ps
`include "e3mon_consts.svh"
module e3mon_top
    import e3mon_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic rx_bit_valid,
    input wire logic rx_bit_data,
    input wire logic rx_frame_end,
    input wire logic rx_a_bit,
    input wire logic [3:0] rx_em_nibble,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic alarm_indication_flag,
    output logic tx_a_bit,
    output logic irq
);
    // ==========================================================
    // frame accumulator
    e3mon_frame_if fr ();

    e3mon_frame_acc u_acc (
        .clock(clock),
        .sys_rst(sys_rst),
        .bit_valid(rx_bit_valid),
        .bit_data(rx_bit_data),
        .frame_end(rx_frame_end),
        .a_bit(rx_a_bit),
        .em_nibble(rx_em_nibble),
        .fr(fr)
    );

    // ==========================================================
    // consecutive frame counting
    // counts frames that oppose the present state; a run of target flips it
    // at-or-above, so a count select lowered mid-run takes effect on the next frame
    function automatic logic [2:0] run_next(input logic [2:0] cnt, input logic opp,
                                            input logic [2:0] target);
        if (!opp || cnt + 3'h1 >= target) begin
            run_next = 3'h0;
        end else begin
            run_next = cnt + 3'h1;
        end
    endfunction

    function automatic logic run_flip(input logic [2:0] cnt, input logic opp,
                                      input logic [2:0] target);
        run_flip = opp && (cnt + 3'h1 >= target);
    endfunction

    // ==========================================================
    // registers
    logic [7:0] cfg1_reg;
    logic [7:0] cfg2_reg;
    logic [7:0] ien1_reg;
    logic [7:0] ien2_reg;
    logic [7:0] ist1_reg;
    logic [7:0] ist2_reg;
    e3mon_cond_e ais_reg;
    e3mon_cond_e ferf_reg;
    logic [2:0] ais_cnt_reg;
    logic [2:0] ferf_cnt_reg;
    e3mon_bip_t prev_bip_reg;
    logic prev_valid_reg;
    logic [2:0] ferf_target;
    logic ais_opp;
    logic ferf_opp;
    logic ais_flip;
    logic ferf_flip;
    logic par_en;
    logic cmp_now;
    logic bip_err;
    logic take;
    logic wr;
    logic rd;
    logic [5:0] idx;
    logic [7:0] ist1_set;
    logic [7:0] ist2_set;
    logic [7:0] ist1_clr;
    logic [7:0] ist2_clr;

    assign par_en = cfg1_reg[`E3M_CFG1_PAR_EN];
    assign ferf_target = cfg1_reg[`E3M_CFG1_FERF_SEL] ? `E3M_FERF_FRAMES_B
                                                        : `E3M_FERF_FRAMES_A;
    assign ais_opp = (ais_reg == E3M_COND_ACTIVE) ? !fr.few_zeros : fr.few_zeros;
    assign ferf_opp = (ferf_reg == E3M_COND_ACTIVE) ? !fr.a_bit : fr.a_bit;
    assign ais_flip = fr.done && run_flip(ais_cnt_reg, ais_opp, `E3M_AIS_FRAMES);
    assign ferf_flip = fr.done && run_flip(ferf_cnt_reg, ferf_opp, ferf_target);
    // the first frame after enabling has no stored bip, so nothing is compared
    assign cmp_now = fr.done && par_en && prev_valid_reg;
    assign bip_err = cmp_now && (fr.em != prev_bip_reg);

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = take && wb_we_i && wb_sel_i[0];
    assign rd = take && !wb_we_i;
    assign idx = wb_adr_i[7:2];

    // ==========================================================
    // alarm indication condition
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ais_reg <= E3M_COND_CLEAR;
            ais_cnt_reg <= 3'h0;
            alarm_indication_flag <= 1'b0;
        end else if (fr.done) begin
            ais_cnt_reg <= run_next(ais_cnt_reg, ais_opp, `E3M_AIS_FRAMES);
            if (ais_flip) begin
                ais_reg <= (ais_reg == E3M_COND_ACTIVE) ? E3M_COND_CLEAR
                                                        : E3M_COND_ACTIVE;
                alarm_indication_flag <= (ais_reg != E3M_COND_ACTIVE);
            end
        end
    end

    // ==========================================================
    // far-end receive failure condition
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ferf_reg <= E3M_COND_CLEAR;
            ferf_cnt_reg <= 3'h0;
        end else if (fr.done) begin
            ferf_cnt_reg <= run_next(ferf_cnt_reg, ferf_opp, ferf_target);
            if (ferf_flip) begin
                ferf_reg <= (ferf_reg == E3M_COND_ACTIVE) ? E3M_COND_CLEAR
                                                          : E3M_COND_ACTIVE;
            end
        end
    end

    // ==========================================================
    // bip-4 check and outgoing a bit
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prev_bip_reg <= 4'h0;
            prev_valid_reg <= 1'b0;
            tx_a_bit <= 1'b0;
        end else if (!par_en) begin
            prev_valid_reg <= 1'b0;
            tx_a_bit <= 1'b0;
        end else if (fr.done) begin
            prev_bip_reg <= fr.bip;
            prev_valid_reg <= 1'b1;
            if (cmp_now) begin
                tx_a_bit <= bip_err;
            end
        end
    end

    // ==========================================================
    // interrupt status: set wins over read clear and write-one clear
    always_comb begin
        ist1_set = 8'h00;
        ist2_set = 8'h00;
        ist1_set[`E3M_IST1_AIS] = ais_flip;
        ist2_set[`E3M_IST2_FERF] = ferf_flip;
        ist2_set[`E3M_IST2_BIP] = bip_err;
        ist1_clr = 8'h00;
        ist2_clr = 8'h00;
        if (rd && idx == `E3M_IDX_IST1) begin
            ist1_clr = 8'hFF;
        end
        if (rd && idx == `E3M_IDX_IST2) begin
            ist2_clr = 8'hFF;
        end
        if (wr && idx == `E3M_IDX_IST1) begin
            ist1_clr = wb_dat_i[7:0];
        end
        if (wr && idx == `E3M_IDX_IST2) begin
            ist2_clr = wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ist1_reg <= `E3M_RST_IST;
            ist2_reg <= `E3M_RST_IST;
        end else begin
            ist1_reg <= (ist1_reg & ~ist1_clr) | ist1_set;
            ist2_reg <= (ist2_reg & ~ist2_clr) | ist2_set;
        end
    end

    // one cycle behind the status bits, so the pin comes from a flop
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ist1_reg & ien1_reg) || |(ist2_reg & ien2_reg);
        end
    end

    // ==========================================================
    // software writable registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg1_reg <= `E3M_RST_CFG1;
            cfg2_reg <= `E3M_RST_CFG2;
            ien1_reg <= `E3M_RST_IEN;
            ien2_reg <= `E3M_RST_IEN;
        end else if (wr) begin
            unique case (idx)
                `E3M_IDX_CFG1: cfg1_reg <= wb_dat_i[7:0] & 8'h11;
                `E3M_IDX_CFG2: cfg2_reg <= wb_dat_i[7:0] & 8'h80;
                `E3M_IDX_IEN1: ien1_reg <= wb_dat_i[7:0] & 8'h01;
                `E3M_IDX_IEN2: ien2_reg <= wb_dat_i[7:0] & 8'h0C;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // wishbone answer: ack one cycle after the request, data registered
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= take;
            if (rd) begin
                unique case (idx)
                    `E3M_IDX_CFG1: wb_dat_o <= {24'h000000, cfg1_reg};
                    `E3M_IDX_CFG2: wb_dat_o <= {24'h000000, cfg2_reg[7], 3'h0,
                                                ais_reg == E3M_COND_ACTIVE, 2'h0,
                                                ferf_reg == E3M_COND_ACTIVE};
                    `E3M_IDX_IEN1: wb_dat_o <= {24'h000000, ien1_reg};
                    `E3M_IDX_IEN2: wb_dat_o <= {24'h000000, ien2_reg};
                    `E3M_IDX_IST1: wb_dat_o <= {24'h000000, ist1_reg};
                    `E3M_IDX_IST2: wb_dat_o <= {24'h000000, ist2_reg};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================================
    // checks
    property p_ais_declare;
        @(posedge clock) disable iff (sys_rst)
        fr.done && ais_reg == E3M_COND_CLEAR && fr.few_zeros && ais_cnt_reg == 3'h1
        |=> alarm_indication_flag && ais_reg == E3M_COND_ACTIVE;
    endproperty
    a_ais_declare: assert property (p_ais_declare) else $error("alarm not declared");

    property p_ais_clear;
        @(posedge clock) disable iff (sys_rst)
        fr.done && ais_reg == E3M_COND_ACTIVE && !fr.few_zeros && ais_cnt_reg == 3'h1
        |=> !alarm_indication_flag ##1 !alarm_indication_flag;
    endproperty
    a_ais_clear: assert property (p_ais_clear) else $error("alarm not cleared");

    property p_ais_int;
        @(posedge clock) disable iff (sys_rst)
        $changed(ais_reg) |-> ist1_reg[`E3M_IST1_AIS];
    endproperty
    a_ais_int: assert property (p_ais_int) else $error("alarm change without status");

    property p_cfg2_read;
        @(posedge clock) disable iff (sys_rst)
        rd && idx == `E3M_IDX_CFG2 |=> wb_ack_o && wb_dat_o[`E3M_CFG2_AIS] == $past(ais_reg)
            && wb_dat_o[`E3M_CFG2_FERF] == $past(ferf_reg);
    endproperty
    a_cfg2_read: assert property (p_cfg2_read) else $error("status bits misread");

    property p_ferf_declare;
        @(posedge clock) disable iff (sys_rst)
        fr.done && ferf_reg == E3M_COND_CLEAR && fr.a_bit && ferf_cnt_reg == ferf_target - 3'h1
        |=> ferf_reg == E3M_COND_ACTIVE;
    endproperty
    a_ferf_declare: assert property (p_ferf_declare) else $error("failure missed");

    property p_ferf_clear;
        @(posedge clock) disable iff (sys_rst)
        fr.done && ferf_reg == E3M_COND_ACTIVE && !fr.a_bit
        && ferf_cnt_reg == ferf_target - 3'h1 |=> ferf_reg == E3M_COND_CLEAR;
    endproperty
    a_ferf_clear: assert property (p_ferf_clear) else $error("failure not cleared");

    property p_ferf_int;
        @(posedge clock) disable iff (sys_rst)
        $changed(ferf_reg) |-> ist2_reg[`E3M_IST2_FERF];
    endproperty
    a_ferf_int: assert property (p_ferf_int) else $error("failure change no status");

    property p_bip_err;
        @(posedge clock) disable iff (sys_rst)
        fr.done && par_en && prev_valid_reg && fr.em != prev_bip_reg
        |=> tx_a_bit && ist2_reg[`E3M_IST2_BIP];
    endproperty
    a_bip_err: assert property (p_bip_err) else $error("bip error missed");

    property p_bip_ok;
        @(posedge clock) disable iff (sys_rst)
        fr.done && par_en && prev_valid_reg && fr.em == prev_bip_reg |=> !tx_a_bit;
    endproperty
    a_bip_ok: assert property (p_bip_ok) else $error("bip match sent a one");

    property p_bip_off;
        @(posedge clock) disable iff (sys_rst)
        !par_en |=> !tx_a_bit && !ist2_set[`E3M_IST2_BIP];
    endproperty
    a_bip_off: assert property (p_bip_off) else $error("check ran while disabled");

    property p_irq;
        @(posedge clock) disable iff (sys_rst)
        ist2_reg[`E3M_IST2_BIP] && ien2_reg[`E3M_IST2_BIP] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_read_clear;
        @(posedge clock) disable iff (sys_rst)
        rd && idx == `E3M_IDX_IST2 && !fr.done |=> ist2_reg == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status not cleared");
endmodule

// >>> design/e3mon_consts.svh
// register map, field positions, reset values and frame counts of the e3 receive monitor
`ifndef E3MON_CONSTS_SVH
`define E3MON_CONSTS_SVH

// register indices; byte address is four times the index
`define E3M_IDX_CFG1 6'h10
`define E3M_IDX_CFG2 6'h11
`define E3M_IDX_IEN1 6'h12
`define E3M_IDX_IEN2 6'h13
`define E3M_IDX_IST1 6'h14
`define E3M_IDX_IST2 6'h15

// field positions
`define E3M_CFG1_FERF_SEL 4
`define E3M_CFG1_PAR_EN 0
`define E3M_CFG2_LOF_SEL 7
`define E3M_CFG2_AIS 3
`define E3M_CFG2_FERF 0
`define E3M_IST1_AIS 0
`define E3M_IST2_FERF 3
`define E3M_IST2_BIP 2

// reset values
`define E3M_RST_CFG1 8'h00
`define E3M_RST_CFG2 8'h00
`define E3M_RST_IEN 8'h00
`define E3M_RST_IST 8'h00

// frame counts and the zero limit of one frame
`define E3M_AIS_FRAMES 3'h2
`define E3M_AIS_MAX_ZEROS 4'h7
`define E3M_FERF_FRAMES_A 3'h3
`define E3M_FERF_FRAMES_B 3'h5

`endif

// >>> design/e3mon_pkg.sv
// types shared by the e3 receive monitor modules
package e3mon_pkg;
    typedef enum logic [0:0] {
        E3M_COND_CLEAR = 1'b0,
        E3M_COND_ACTIVE = 1'b1
    } e3mon_cond_e;
    typedef logic [3:0] e3mon_bip_t;
endpackage

// >>> design/e3mon_frame_if.sv
// per-frame results handed from the accumulator to the monitor core
`timescale 1ns/1ps
interface e3mon_frame_if;
    import e3mon_pkg::*;
    logic done;
    e3mon_bip_t bip;
    e3mon_bip_t em;
    logic few_zeros;
    logic a_bit;
    modport acc (output done, output bip, output em, output few_zeros, output a_bit);
    modport mon (input done, input bip, input em, input few_zeros, input a_bit);
endinterface

// >>> design/e3mon_frame_acc.sv
// accumulates bip-4 and zero count over one received frame
`timescale 1ns/1ps
`include "e3mon_consts.svh"
module e3mon_frame_acc
    import e3mon_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic bit_valid,
    input wire logic bit_data,
    input wire logic frame_end,
    input wire logic a_bit,
    input wire logic [3:0] em_nibble,
    e3mon_frame_if.acc fr
);
    logic [1:0] lane_reg;
    e3mon_bip_t par_reg;
    e3mon_bip_t par_next;
    logic [3:0] zeros_reg;
    logic [3:0] zeros_next;

    // bit i of the frame folds into parity lane i mod 4
    always_comb begin
        par_next = par_reg;
        par_next[lane_reg] = par_reg[lane_reg] ^ bit_data;
        zeros_next = zeros_reg;
        // saturate: only "seven or fewer" matters
        if (!bit_data && zeros_reg <= `E3M_AIS_MAX_ZEROS) begin
            zeros_next = zeros_reg + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            lane_reg <= 2'h0;
            par_reg <= 4'h0;
            zeros_reg <= 4'h0;
        end else if (bit_valid) begin
            lane_reg <= frame_end ? 2'h0 : lane_reg + 2'h1;
            par_reg <= frame_end ? 4'h0 : par_next;
            zeros_reg <= frame_end ? 4'h0 : zeros_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fr.done <= 1'b0;
            fr.bip <= 4'h0;
            fr.em <= 4'h0;
            fr.few_zeros <= 1'b0;
            fr.a_bit <= 1'b0;
        end else begin
            fr.done <= bit_valid & frame_end;
            if (bit_valid && frame_end) begin
                fr.bip <= par_next;
                fr.em <= em_nibble;
                fr.few_zeros <= zeros_next <= `E3M_AIS_MAX_ZEROS;
                fr.a_bit <= a_bit;
            end
        end
    end
endmodule

// >>> test/e3mon_line_model.sv
// line-side model of the remote e3 terminal, sending whole frames on request
`timescale 1ns/1ps
module e3mon_line_model
    import e3mon_pkg::*;
#(
    parameter int FRAME_BITS = 16
)
(
    input wire logic clock,
    output logic rx_bit_valid,
    output logic rx_bit_data,
    output logic rx_frame_end,
    output logic rx_a_bit,
    output logic [3:0] rx_em_nibble
);
    // ==========================================================
    // frame sender
    e3mon_bip_t last_bip;
    initial begin
        rx_bit_valid = 1'b0;
        rx_bit_data = 1'b1;
        rx_frame_end = 1'b0;
        rx_a_bit = 1'b1;
        rx_em_nibble = 4'hF;
        last_bip = 4'h0;
    end
    // zeros lead the frame; bad_em corrupts the parity carried for the previous frame
    task automatic send_frame(input int zeros, input logic a_val, input logic bad_em);
        e3mon_bip_t bip;
        logic b;
        bip = 4'h0;
        b = 1'b0;
        for (int i = 0; i < FRAME_BITS; i++) begin
            b = (i >= zeros);
            bip[i % 4] = bip[i % 4] ^ b;
            @(posedge clock);
            rx_bit_valid <= 1'b1;
            rx_bit_data <= b;
            rx_frame_end <= (i == FRAME_BITS - 1);
            rx_a_bit <= a_val;
            rx_em_nibble <= last_bip ^ {3'h0, bad_em};
        end
        @(posedge clock);
        // idle line: no stale value left standing on the data lines
        rx_bit_valid <= 1'b0;
        rx_bit_data <= ~b;
        rx_frame_end <= 1'b0;
        rx_a_bit <= ~a_val;
        rx_em_nibble <= ~(last_bip ^ {3'h0, bad_em});
        last_bip = bip;
    endtask
endmodule

// >>> test/e3_rx_ais_ferf_bip4_monitor_tb.sv
// self-checking testbench of the e3 receive alarm and bip-4 monitor
`timescale 1ns/1ps
`include "e3mon_consts.svh"
module e3_rx_ais_ferf_bip4_monitor_tb;
    import e3mon_pkg::*;
    typedef struct {
        int zeros;
        logic a;
        logic bad;
        logic alarm;
        logic tx;
    } e3mon_row_s;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic rx_bit_valid, rx_bit_data, rx_frame_end, rx_a_bit;
    logic [3:0] rx_em_nibble;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, alarm_indication_flag, tx_a_bit, irq;
    int miscompares = 0;
    int compares = 0;
    // first row is the first frame after enabling, so it is never compared
    e3mon_row_s rows [8] = '{'{16, 1'b0, 1'b0, 1'b0, 1'b0}, '{8, 1'b0, 1'b0, 1'b0, 1'b0},
        '{7, 1'b0, 1'b1, 1'b0, 1'b1}, '{0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{8, 1'b0, 1'b0, 1'b1, 1'b0}, '{7, 1'b0, 1'b0, 1'b1, 1'b0},
        '{8, 1'b0, 1'b0, 1'b1, 1'b0}, '{16, 1'b0, 1'b0, 1'b0, 1'b0}};

    always #25 clock = ~clock;

    e3mon_line_model line_u (.clock(clock), .rx_bit_valid(rx_bit_valid),
        .rx_bit_data(rx_bit_data), .rx_frame_end(rx_frame_end), .rx_a_bit(rx_a_bit),
        .rx_em_nibble(rx_em_nibble));
    e3mon_top dut_u (.clock(clock), .sys_rst(sys_rst), .rx_bit_valid(rx_bit_valid),
        .rx_bit_data(rx_bit_data), .rx_frame_end(rx_frame_end), .rx_a_bit(rx_a_bit),
        .rx_em_nibble(rx_em_nibble), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .alarm_indication_flag(alarm_indication_flag), .tx_a_bit(tx_a_bit), .irq(irq));

    // ==========================================================
    // shared tasks
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
            miscompares++;
        end
    endtask
    // the slave sets the pace: wait for ack; only the watchdog ends a wait
    task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                           output logic [31:0] rd);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] v;
        wb_xfer(1'b1, idx, d, v);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, idx, 8'h00, v);
        check(v, exp);
    endtask
    // results land two edges after the frame end; irq one edge later
    task automatic fr(input int z, input logic a, input logic bad);
        line_u.send_frame(z, a, bad);
        repeat (3) @(posedge clock);
        #1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 16; i < 22; i++) rd(6'(i), 32'h00000000);
        wr(6'h3F, 8'hFF);
        rd(6'h3F, 32'h00000000);
        wr(`E3M_IDX_CFG1, 8'h01);
        wr(`E3M_IDX_IEN1, 8'h01);
        wr(`E3M_IDX_IEN2, 8'h0C);
        foreach (rows[i]) begin
            fr(rows[i].zeros, rows[i].a, rows[i].bad);
            check(32'(alarm_indication_flag), 32'(rows[i].alarm));
            check(32'(tx_a_bit), 32'(rows[i].tx));
            rd(`E3M_IDX_CFG2, {28'h0000000, rows[i].alarm, 3'h0});
        end
        rd(`E3M_IDX_CFG2, 32'h00000000);
        rd(`E3M_IDX_IST1, 32'h00000001);
        rd(`E3M_IDX_IST1, 32'h00000000);
        rd(`E3M_IDX_IST2, 32'h00000004);
        fr(8, 1'b1, 1'b0);
        fr(8, 1'b1, 1'b0);
        rd(`E3M_IDX_CFG2, 32'h00000000);
        fr(8, 1'b1, 1'b0);
        rd(`E3M_IDX_CFG2, 32'h00000001);
        check(32'(irq), 32'h1);
        rd(`E3M_IDX_IST2, 32'h00000008);
        @(posedge clock);
        check(32'(irq), 32'h0);
        wr(`E3M_IDX_CFG1, 8'h11);
        repeat (4) fr(8, 1'b0, 1'b0);
        rd(`E3M_IDX_CFG2, 32'h00000001);
        fr(8, 1'b0, 1'b0);
        rd(`E3M_IDX_CFG2, 32'h00000000);
        rd(`E3M_IDX_IST2, 32'h00000008);
        // a standing error flag must be dropped when checking is switched off
        fr(8, 1'b0, 1'b1);
        check(32'(tx_a_bit), 32'h1);
        rd(`E3M_IDX_IST2, 32'h00000004);
        wr(`E3M_IDX_CFG1, 8'h10);
        fr(8, 1'b0, 1'b1);
        check(32'(tx_a_bit), 32'h0);
        rd(`E3M_IDX_IST2, 32'h00000000);
        wr(`E3M_IDX_IEN2, 8'h08);
        wr(`E3M_IDX_CFG1, 8'h11);
        fr(8, 1'b0, 1'b1);
        check(32'(tx_a_bit), 32'h0);
        fr(8, 1'b0, 1'b1);
        check(32'(irq), 32'h0);
        wr(`E3M_IDX_IEN2, 8'h0C);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h1);
        wr(`E3M_IDX_IST2, 8'h04);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0);
        rd(`E3M_IDX_IST2, 32'h00000000);
        wr(`E3M_IDX_CFG2, 8'hFF);
        rd(`E3M_IDX_CFG2, 32'h00000080);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check(32'(tx_a_bit), 32'h0);
        rd(`E3M_IDX_CFG1, 32'h00000000);
        rd(`E3M_IDX_CFG2, 32'h00000000);
        report_and_stop();
    end

    // ==========================================================
    // watchdog: the whole sequence needs well under a thousand frames of time
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
endmodule
